/* File: tcu_pkg.sv */
// constants, types and register map for the timer compare unit
`default_nettype none

package tcu_pkg;

  // register indices on the plain register port
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_VALUE_LOW = 3'h1;
  localparam logic [2:0] ADDR_VALUE_HIGH = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_MASK = 3'h4;
  localparam logic [2:0] ADDR_TIMER_LOW = 3'h5;
  localparam logic [2:0] ADDR_TIMER_HIGH = 3'h6;

  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_VALUE = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // field positions
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 3;
  localparam int STAT_MATCH = 0;
  localparam int STAT_TRIGGER = 1;
  localparam int STAT_LATCH = 4;
  localparam int STAT_PENDING = 5;
  localparam int STAT_ACTIVE = 6;
  localparam int EVENT_BITS = 2;

  // compare mode field encodings
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_SW_INT = 4'ha;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;

  // pin action requested on a match
  typedef enum logic [1:0] {
    TCU_PIN_NONE = 2'b00,
    TCU_PIN_SET = 2'b01,
    TCU_PIN_CLEAR = 2'b11,
    TCU_PIN_TOGGLE = 2'b10
  } tcu_pin_act_t;

  // timer-reset arming, gray coded
  typedef enum logic [1:0] {
    TCU_TRIG_IDLE = 2'b00,
    TCU_TRIG_ARMED = 2'b01
  } tcu_trig_t;

endpackage : tcu_pkg

`default_nettype wire

/* File: tcu_match.sv */
// match detection and special event trigger arming
`timescale 1ns/1ps
`default_nettype none

module tcu_match (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_active,
  input wire logic i_special,
  input wire logic i_sleep,
  input wire logic [15:0] i_value,
  input wire logic [15:0] i_count,
  input wire logic i_timer_tick,
  output logic o_match_pulse,
  output logic o_trigger,
  output logic o_timer_clear,
  output logic o_pending
);

  tcu_pkg::tcu_trig_t state;
  tcu_pkg::tcu_trig_t next_state;
  logic match_q;
  wire logic equal;
  wire logic match_now;

  // full-width equality, live every cycle; gated off in sleep
  assign equal = (i_value == i_count);
  assign match_now = i_active && !i_sleep && equal;

  // one action per match episode, not one per cycle of equality
  assign o_match_pulse = match_now && !match_q;
  // no register in this path: trigger appears in the match cycle
  assign o_trigger = o_match_pulse && i_special;
  // clear only granted on a timer edge and while match still holds
  assign o_timer_clear = (state == tcu_pkg::TCU_TRIG_ARMED) && i_timer_tick
                         && match_now;
  assign o_pending = (state == tcu_pkg::TCU_TRIG_ARMED);

  // arming state
  always_comb
  begin
    next_state = state;
    case (state)
      tcu_pkg::TCU_TRIG_IDLE:
      begin
        if (o_trigger)
          next_state = tcu_pkg::TCU_TRIG_ARMED;
      end
      tcu_pkg::TCU_TRIG_ARMED:
      begin
        // match removed by a rewrite drops the pending reset
        if (!match_now || i_timer_tick)
          next_state = tcu_pkg::TCU_TRIG_IDLE;
      end
      default: next_state = tcu_pkg::TCU_TRIG_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= tcu_pkg::TCU_TRIG_IDLE;
      match_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      match_q <= match_now;
    end
  end

endmodule : tcu_match

`default_nettype wire

/* File: tcu_irq.sv */
// sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none

module tcu_irq (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_events,
  input wire logic i_clear_wr,
  input wire logic [1:0] i_clear_bits,
  input wire logic i_mask_wr,
  input wire logic [1:0] i_mask_bits,
  output logic [1:0] o_status,
  output logic [1:0] o_mask,
  output logic o_irq
);

  wire logic [1:0] next_status;

  // set beats write-one-to-clear in the same cycle
  assign next_status = i_events | (o_status & ~({2{i_clear_wr}} & i_clear_bits));
  assign o_irq = |(o_status & o_mask);

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_status <= 2'h0;
      o_mask <= 2'h0;
    end
    else
    begin
      o_status <= next_status;
      if (i_mask_wr)
        o_mask <= i_mask_bits;
    end
  end

endmodule : tcu_irq

`default_nettype wire

/* File: tcu_top.sv */
// timer compare unit: registers, pin latch and timer/converter triggers
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module tcu_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [15:0] i_timer_count,
  input wire logic i_timer_tick,
  input wire logic i_adc_enable,
  input wire logic i_sleep,
  output logic o_special_event,
  output logic o_timer_clear,
  output logic o_adc_start,
  output logic o_pin_out,
  output logic o_pin_oe_n,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////
  // registers and decode

  logic [7:0] compare_control;
  logic [7:0] compare_value_low;
  logic [7:0] compare_value_high;
  logic out_latch;
  logic [7:0] next_rdata;

  wire logic [3:0] compare_mode_field;
  wire logic wr_control;
  wire logic wr_low;
  wire logic wr_high;
  wire logic wr_status;
  wire logic wr_mask;
  wire logic active;
  wire logic special;
  wire logic pin_owned;
  wire logic match_pulse;
  wire logic pending;
  wire logic [1:0] status;
  wire logic [1:0] mask;
  wire logic [15:0] compare_value;
  tcu_pkg::tcu_pin_act_t pin_act;

  // mode to pin action; unknown codes do nothing
  function automatic tcu_pkg::tcu_pin_act_t mode_action(input logic [3:0] mode);
    case (mode)
      tcu_pkg::MODE_SET: mode_action = tcu_pkg::TCU_PIN_SET;
      tcu_pkg::MODE_CLEAR: mode_action = tcu_pkg::TCU_PIN_CLEAR;
      tcu_pkg::MODE_TOGGLE: mode_action = tcu_pkg::TCU_PIN_TOGGLE;
      default: mode_action = tcu_pkg::TCU_PIN_NONE;
    endcase
  endfunction : mode_action

  // is the mode one of the compare modes
  function automatic logic mode_is_compare(input logic [3:0] mode);
    mode_is_compare = (mode_action(mode) != tcu_pkg::TCU_PIN_NONE)
                      || (mode == tcu_pkg::MODE_SW_INT)
                      || (mode == tcu_pkg::MODE_SPECIAL);
  endfunction : mode_is_compare

  // address decode
  assign wr_control = i_wr && (i_addr == tcu_pkg::ADDR_CONTROL);
  assign wr_low = i_wr && (i_addr == tcu_pkg::ADDR_VALUE_LOW);
  assign wr_high = i_wr && (i_addr == tcu_pkg::ADDR_VALUE_HIGH);
  assign wr_status = i_wr && (i_addr == tcu_pkg::ADDR_STATUS);
  assign wr_mask = i_wr && (i_addr == tcu_pkg::ADDR_MASK);

  // mode derived wires
  assign compare_mode_field = compare_control[tcu_pkg::MODE_MSB:tcu_pkg::MODE_LSB];
  assign compare_value = {compare_value_high, compare_value_low};
  assign active = mode_is_compare(compare_mode_field);
  assign special = (compare_mode_field == tcu_pkg::MODE_SPECIAL);
  assign pin_act = mode_action(compare_mode_field);
  // software interrupt and trigger modes leave the pin alone
  assign pin_owned = (pin_act != tcu_pkg::TCU_PIN_NONE);

  // register storage
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      compare_control <= tcu_pkg::RST_CONTROL;
      compare_value_low <= tcu_pkg::RST_VALUE;
      compare_value_high <= tcu_pkg::RST_VALUE;
    end
    else
    begin
      if (wr_control)
        compare_control <= i_wdata;
      if (wr_low)
        compare_value_low <= i_wdata;
      if (wr_high)
        compare_value_high <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // match engine

  tcu_match u_match (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_active(active),
    .i_special(special),
    .i_sleep(i_sleep),
    .i_value(compare_value),
    .i_count(i_timer_count),
    .i_timer_tick(i_timer_tick),
    .o_match_pulse(match_pulse),
    .o_trigger(o_special_event),
    .o_timer_clear(o_timer_clear),
    .o_pending(pending)
  );

  // conversion start rides the trigger pulse; disabled converter ignores it
  assign o_adc_start = o_special_event && i_adc_enable;
  // o_timer_clear is a clear, not a rollover: overflow flag stays quiet

  ////////////////////////////////////////////////////////////////
  // compare output latch and pin

  // latch only moves on a match action or a zero control write
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      out_latch <= 1'b0;
    else if (wr_control && (i_wdata == 8'h00))
      out_latch <= 1'b0;
    else if (match_pulse)
    begin
      case (pin_act)
        tcu_pkg::TCU_PIN_SET: out_latch <= 1'b1;
        tcu_pkg::TCU_PIN_CLEAR: out_latch <= 1'b0;
        tcu_pkg::TCU_PIN_TOGGLE: out_latch <= ~out_latch;
        default: out_latch <= out_latch;
      endcase
    end
  end

  // driver enable only in pin modes; port direction bit lives outside
  assign o_pin_out = out_latch;
  assign o_pin_oe_n = !pin_owned;

  ////////////////////////////////////////////////////////////////
  // interrupt

  tcu_irq u_irq (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_events({o_special_event, match_pulse}),
    .i_clear_wr(wr_status),
    .i_clear_bits(i_wdata[1:0]),
    .i_mask_wr(wr_mask),
    .i_mask_bits(i_wdata[1:0]),
    .o_status(status),
    .o_mask(mask),
    .o_irq(o_irq)
  );

  ////////////////////////////////////////////////////////////////
  // read path, data one cycle after the strobe

  always_comb
  begin
    next_rdata = tcu_pkg::RD_UNMAPPED;
    case (i_addr)
      tcu_pkg::ADDR_CONTROL: next_rdata = compare_control;
      tcu_pkg::ADDR_VALUE_LOW: next_rdata = compare_value_low;
      tcu_pkg::ADDR_VALUE_HIGH: next_rdata = compare_value_high;
      tcu_pkg::ADDR_STATUS:
      begin
        next_rdata[1:0] = status;
        next_rdata[tcu_pkg::STAT_LATCH] = out_latch;
        next_rdata[tcu_pkg::STAT_PENDING] = pending;
        next_rdata[tcu_pkg::STAT_ACTIVE] = active;
      end
      tcu_pkg::ADDR_MASK: next_rdata[1:0] = mask;
      tcu_pkg::ADDR_TIMER_LOW: next_rdata = i_timer_count[7:0];
      tcu_pkg::ADDR_TIMER_HIGH: next_rdata = i_timer_count[15:8];
      default: next_rdata = tcu_pkg::RD_UNMAPPED;
    endcase
  end

  // read data held only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else if (i_rd)
      o_rdata <= next_rdata;
    else
      o_rdata <= 8'h00;
  end

endmodule : tcu_top

`default_nettype wire

/* File: tcu_timer_model.sv */
// timer partner model: divided-rate counter that clears on request
`timescale 1ns/1ps
`default_nettype none

module tcu_timer_model #(parameter int DIV = 4) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  output logic [15:0] o_count,
  output logic o_tick,
  output logic o_ovf
);
  logic [7:0] div;

  ////////////////////////////////////////////////////////////////////////////
  // synchronous tick once per DIV cycles, never the raw clock
  assign o_tick = (div == 8'(DIV - 1));

  // a clear lands only on a tick and leaves the overflow flag alone
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div <= 8'h00;
      o_count <= 16'h0000;
      o_ovf <= 1'b0;
    end
    else
    begin
      div <= o_tick ? 8'h00 : div + 8'h01;
      if (o_tick)
        o_count <= i_clear ? 16'h0000 : o_count + 16'h0001;
      if (o_tick && !i_clear && o_count == 16'hffff)
        o_ovf <= 1'b1;
    end
  end
endmodule : tcu_timer_model

`default_nettype wire

/* File: tcu_assertions.sv */
// concurrent checks on the timer compare unit ports
`timescale 1ns/1ps
`default_nettype none

module tcu_assertions (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [15:0] i_timer_count,
  input wire logic i_timer_tick,
  input wire logic i_adc_enable,
  input wire logic i_sleep,
  input wire logic o_special_event,
  input wire logic o_timer_clear,
  input wire logic o_adc_start,
  input wire logic o_pin_out,
  input wire logic o_pin_oe_n,
  input wire logic o_irq
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // control write decode, mode sits in the low nibble
  wire ctl_wr = i_wr && i_addr == tcu_pkg::ADDR_CONTROL;

  ////////////////////////////////////////////////////////////////////////////
  a_adc_follow: assert property (o_adc_start == (o_special_event && i_adc_enable))
    else $error("adc start not tied to trigger");
  a_sleep_quiet: assert property (i_sleep |-> !o_special_event && !o_timer_clear)
    else $error("trigger while sleeping");
  a_trig_single: assert property (o_special_event |=> !o_special_event)
    else $error("trigger longer than one cycle");
  a_clear_tick: assert property (o_timer_clear |-> i_timer_tick && !o_special_event)
    else $error("timer clear off its tick");
  a_zero_ctl: assert property (ctl_wr && i_wdata == 8'h00 |=> !o_pin_out && o_pin_oe_n)
    else $error("zero control left latch or driver");
  a_flag_free: assert property (ctl_wr && i_wdata[3] && i_wdata[1] |=> o_pin_oe_n)
    else $error("pin driven in flag or trigger mode");
  a_set_drive: assert property (ctl_wr && i_wdata[3:0] == tcu_pkg::MODE_SET |=> !o_pin_oe_n)
    else $error("pin not driven in set mode");
  // latch may move only after a control write, or while awake in a pin mode; the check does not look at the match itself
  a_latch_hold: assert property (!$stable(o_pin_out) |-> $past(ctl_wr) ||
    (!$past(i_sleep) && $past(!o_pin_oe_n)))
    else $error("latch moved without a match");
  c_trig: cover property (o_special_event && i_adc_enable);
  c_clear: cover property (o_timer_clear);
  c_irq: cover property ($rose(o_irq));
endmodule : tcu_assertions

bind tcu_top tcu_assertions tcu_assertions_inst (.i_sys_clk, .i_rst_n, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_timer_count, .i_timer_tick, .i_adc_enable, .i_sleep,
  .o_special_event, .o_timer_clear, .o_adc_start, .o_pin_out, .o_pin_oe_n, .o_irq);

`default_nettype wire

/* File: tcu_tb.sv */
// self-checking bench for the timer compare unit
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rd_q = 1'b0;
  logic i_adc_enable = 1'b0, i_sleep = 1'b0, t_rst_n = 1'b0, lat = 1'b0, hit;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, v;
  logic [15:0] i_timer_count;
  logic i_timer_tick, o_special_event, o_timer_clear, o_adc_start, o_pin_out;
  logic o_pin_oe_n, o_irq, ovf;
  logic [3:0] m;
  logic [3:0] modes [8] = '{4'h2, 4'h8, 4'h9, 4'h2, 4'ha, 4'hb, 4'h5, 4'h8};
  logic [7:0] q_exp [$], q_msk [$];
  int mismatches = 0, n_tests = 0, n_adc = 0, n_clr = 0, a0, w;

  always #12.5 i_sys_clk = ~i_sys_clk;
  tcu_top tcu_top_inst (.i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_timer_count, .i_timer_tick, .i_adc_enable, .i_sleep, .o_special_event,
    .o_timer_clear, .o_adc_start, .o_pin_out, .o_pin_oe_n, .o_irq);
  tcu_timer_model tcu_timer_model_inst (.i_clk(i_sys_clk), .i_rst_n(t_rst_n),
    .i_clear(o_timer_clear), .o_count(i_timer_count), .o_tick(i_timer_tick), .o_ovf(ovf));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // strobes drop for a cycle so no signal is assigned twice in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] k);
    q_exp.push_back(e);
    q_msk.push_back(k);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(posedge i_sys_clk);
  endtask : rd

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // monitor: read data stands only in the cycle after the strobe
  always @(posedge i_sys_clk)
  begin
    rd_q <= i_rd;
    n_adc += o_adc_start;
    n_clr += o_timer_clear;
    if (rd_q)
    begin
      chk(o_rdata & q_msk[0], q_exp[0] & q_msk[0]);
      void'(q_exp.pop_front());
      void'(q_msk.pop_front());
    end
  end

  // watchdog at 20000 cycles, well past the fewer than 2000 cycles the tests need
  initial
  begin
    #500000;
    mismatches++;
    end_sim();
  end

  initial
  begin
    void'($urandom(69690));
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    rd(tcu_pkg::ADDR_CONTROL, tcu_pkg::RST_CONTROL, 8'hff);
    rd(tcu_pkg::ADDR_MASK, tcu_pkg::RST_MASK, 8'hff);
    wr(3'h7, 8'hff);
    rd(3'h7, tcu_pkg::RD_UNMAPPED, 8'hff);
    wr(tcu_pkg::ADDR_MASK, 8'h01);
    $display("reset and map test done");
    // each compare mode in turn plus unmapped code 5; the last entry repeats set mode while asleep
    for (int i = 0; i < 8; i++)
    begin
      m = modes[i];
      v = 8'h08 + 8'($urandom % 32);
      t_rst_n <= 1'b0;
      i_sleep <= (i == 7);
      i_adc_enable <= 1'($urandom % 2);
      wr(tcu_pkg::ADDR_VALUE_HIGH, 8'h00);
      wr(tcu_pkg::ADDR_STATUS, 8'h03);
      wr(tcu_pkg::ADDR_VALUE_LOW, v);
      wr(tcu_pkg::ADDR_CONTROL, {4'h0, m});
      a0 = n_adc;
      t_rst_n <= 1'b1;
      repeat (4 * v + 12) @(posedge i_sys_clk);
      hit = (i != 7) && (m != 4'h5);
      if (hit && m != 4'ha && m != 4'hb)
        lat = (m == 4'h8) ? 1'b1 : (m == 4'h9) ? 1'b0 : !lat;
      rd(tcu_pkg::ADDR_STATUS, {3'h0, lat, 2'h0, hit && m == 4'hb, hit}, 8'h33);
      chk(8'(o_pin_out), 8'(lat));
      // direction bit is the software's; the bench only sees the driver enable
      chk(8'(o_pin_oe_n), 8'(m != 4'h2 && m != 4'h8 && m != 4'h9));
      chk(8'(o_irq), 8'(hit));
      chk(8'(n_adc - a0), 8'(hit && m == 4'hb && i_adc_enable));
      chk(8'(i_timer_count < 16'(v)), 8'(hit && m == 4'hb));
      chk(8'(ovf), 8'h00);
      $display("mode %h test done", m);
    end
    // rewrite the value between trigger and tick: the reset must not happen
    t_rst_n <= 1'b0;
    i_sleep <= 1'b0;
    wr(tcu_pkg::ADDR_VALUE_LOW, 8'h10);
    wr(tcu_pkg::ADDR_CONTROL, {4'h0, tcu_pkg::MODE_SPECIAL});
    a0 = n_clr;
    t_rst_n <= 1'b1;
    w = 0;
    while (o_special_event !== 1'b1 && w < 200)
    begin
      @(posedge i_sys_clk);
      w++;
    end
    // a trigger that never came would leave the cancel check vacuous
    chk(8'(w < 200), 8'h01);
    wr(tcu_pkg::ADDR_VALUE_LOW, 8'h30);
    repeat (8) @(posedge i_sys_clk);
    chk(8'(n_clr - a0), 8'h00);
    rd(tcu_pkg::ADDR_STATUS, 8'h03, 8'h23);
    // count still past the old match value: no clear slipped through
    rd(tcu_pkg::ADDR_TIMER_HIGH, 8'h00, 8'hff);
    rd(tcu_pkg::ADDR_TIMER_LOW, 8'h10, 8'hf0);
    wr(tcu_pkg::ADDR_CONTROL, {4'h0, tcu_pkg::MODE_SET});
    wr(tcu_pkg::ADDR_CONTROL, 8'h00);
    chk({6'h0, o_pin_out, o_pin_oe_n}, 8'h01);
    $display("cancel and clear test done");
    end_sim();
  end
endmodule : testbench

`default_nettype wire
